// ### rtc_status_pkg.sv
// Constants shared by the clock status, prescaler, wakeup and alarm logic
// Notes on behaviour
// - Calibration write sets pending flag until applied
// - Tamper edges set sticky flags, cleared writing 0
// - Stamp event sets flag; repeat sets overflow
// - Wakeup counter reaching zero sets wakeup flag
// - Alarm matches set alarm flags, cleared writing 0
// - Delayed flags clear two cycles after write
// - Init request stops prescaler counters, raises init state
// - Shadow copy sets synced flag; several clears
// - Calendar initialized while year is nonzero
// - Shift write sets pending until shift executes
// - Wakeup write allowed tracks enable within two cycles
// - Alarm write allowed when disabled, not init
// - Only bits 13 to 8 bypass protection
// - Domain reset 0x7; system reset clears three
// - Two-stage prescaler divides by factor plus one
// - Wakeup every reload plus one, 17-bit option
// - BCD compare with masks and weekday select
// - Three-bit wakeup clock selection
package rtc_status_pkg;
  // ----------------------------------------
  // Register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_PRESCALER = 8'h10;
  localparam logic [7:0] OFS_WAKEUP = 8'h14;
  localparam logic [7:0] OFS_ALARM_A = 8'h1C;
  localparam logic [31:0] RST_PRESCALER = 32'h007F00FF;
  localparam logic [31:0] RST_WAKEUP = 32'h0000FFFF;
  localparam logic [31:0] RST_ALARM_A = 32'h00000000;
  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int BIT_RECAL = 16;
  localparam int BIT_TAMPER_TWO = 14;
  localparam int BIT_TAMPER_ONE = 13;
  localparam int BIT_STAMP_OVF = 12;
  localparam int BIT_STAMP = 11;
  localparam int BIT_WAKEUP = 10;
  localparam int BIT_ALARM_B = 9;
  localparam int BIT_ALARM_A = 8;
  localparam int BIT_INIT_REQ = 7;
  localparam int BIT_INIT_STATE = 6;
  localparam int BIT_SYNCED = 5;
  localparam int BIT_CAL_INIT = 4;
  localparam int BIT_SHIFT = 3;
  localparam int BIT_WAKE_WR = 2;
  localparam int BIT_ALB_WR = 1;
  localparam int BIT_ALA_WR = 0;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ASYNC_LSB = 16;
  localparam int ASYNC_W = 7;
  localparam int SYNC_W = 15;
  localparam int RELOAD_W = 16;
  localparam int MSK_SEC = 7;
  localparam int MSK_MIN = 15;
  localparam int MSK_HOUR = 23;
  localparam int MSK_DATE = 31;
  localparam int WEEKDAY_SEL = 30;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLOCK_HZ = 20000000;
  localparam int CLEAR_DELAY_CYCLES = 2;
  localparam logic [2:0] WSEL_DIV2 = 3'h3;
  typedef enum logic [0:0] {WK_IDLE = 1'b0, WK_RUN = 1'b1} wake_state_t;
endpackage : rtc_status_pkg

// ### tick_divider.sv
// Programmable down-counting tick divider
`timescale 1ns/1ps
module tick_divider
  import rtc_status_pkg::*;
#(
  parameter int W = 7
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic hold,
  input wire logic tick_in,
  input wire logic [W-1:0] factor,
  output logic tick_out
);
  logic [W-1:0] count;

  assign tick_out = tick_in && !hold && (count == '0);

  // Divide by factor plus one
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      count <= '0;
    else if (hold)
      count <= factor;
    else if (tick_in)
    begin
      if (count == '0)
        count <= factor;
      else
        count <= count - 1'b1;
    end
  end

  property p_reload;
    @(posedge clock) disable iff (!nrst)
      tick_out |=> (count == $past(factor));
  endproperty
  a_reload: assert property (p_reload) else $error("divider did not reload");
endmodule : tick_divider

// ### alarm_match.sv
// Masked BCD alarm comparison against calendar time and date
`timescale 1ns/1ps
module alarm_match
  import rtc_status_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [31:0] alarm,
  input wire logic [22:0] time_now,
  input wire logic [5:0] date_now,
  input wire logic [2:0] weekday_now,
  output logic match
);
  logic sec_ok;
  logic min_ok;
  logic hour_ok;
  logic day_ok;

  // Mask bits make a field don't care
  assign sec_ok = alarm[MSK_SEC] || (alarm[6:0] == time_now[6:0]);
  assign min_ok = alarm[MSK_MIN] || (alarm[14:8] == time_now[14:8]);
  assign hour_ok = alarm[MSK_HOUR] || (alarm[22:16] == time_now[22:16]);
  assign day_ok = alarm[MSK_DATE] || (alarm[WEEKDAY_SEL]
    ? (alarm[27:24] == {1'b0, weekday_now})
    : (alarm[29:24] == date_now));

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      match <= 1'b0;
    else
      match <= sec_ok && min_ok && hour_ok && day_ok;
  end

  property p_sec_mask;
    @(posedge clock) disable iff (!nrst)
      (!alarm[MSK_SEC] && (alarm[6:0] != time_now[6:0])) |=> !match;
  endproperty
  a_sec_mask: assert property (p_sec_mask) else $error("unmasked seconds mismatch matched");
endmodule : alarm_match

// ### rtc_status_core.sv
// Status, prescaler, wakeup timer and alarm A slice of the clock
`timescale 1ns/1ps
module rtc_status_core
  import rtc_status_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic sys_nrst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic write_unlocked,
  input wire logic calib_write,
  input wire logic calib_applied,
  input wire logic shift_write,
  input wire logic shift_done,
  input wire logic shadow_copy,
  input wire logic shadow_bypass,
  input wire logic tamper_input_one,
  input wire logic tamper_input_two,
  input wire logic stamp_input,
  input wire logic stamp_enable,
  input wire logic wakeup_enable,
  input wire logic [2:0] wakeup_clock_select,
  input wire logic alarm_a_enable,
  input wire logic alarm_b_enable,
  input wire logic alarm_b_match,
  input wire logic [22:0] time_now,
  input wire logic [5:0] date_now,
  input wire logic [2:0] weekday_now,
  input wire logic [7:0] year_now,
  output logic calendar_hold,
  output logic intermediate_clock,
  output logic calendar_step_clock,
  output logic calib_blocked,
  output logic wakeup_event,
  output logic alarm_a_event,
  output logic stamp_event
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic recal_pending_flag;
  logic tamper_two_flag;
  logic tamper_one_flag;
  logic stamp_overflow_flag;
  logic stamp_flag;
  logic wakeup_flag;
  logic alarm_b_flag;
  logic alarm_a_flag;
  logic init_request;
  logic init_state_flag;
  logic shadow_synced_flag;
  logic calendar_initialized;
  logic shift_pending_flag;
  logic wakeup_write_allowed;
  logic alarm_b_write_allowed;
  logic alarm_a_write_allowed;
  logic [31:0] prescaler;
  logic [31:0] wakeup_reload;
  logic [31:0] alarm_a;
  logic [31:0] status;
  logic [3:0] clear_late;
  logic wr_status;
  logic wr_locked;
  logic [2:0] t1_sync;
  logic [2:0] t2_sync;
  logic [2:0] ts_sync;
  logic t1_edge;
  logic t2_edge;
  logic ts_event;
  logic [3:0] kernel_div;
  logic wakeup_clock;
  logic [16:0] wake_count;
  logic [16:0] wake_load;
  logic wake_set;
  wake_state_t wake_state;
  logic match_a;
  logic match_a_prev;
  logic set_a;
  logic set_b;

  assign wr_status = reg_write && (reg_addr == OFS_STATUS);
  assign wr_locked = wr_status && write_unlocked;
  assign calendar_hold = init_state_flag;
  assign calib_blocked = recal_pending_flag;
  assign wakeup_event = wakeup_flag;
  assign alarm_a_event = alarm_a_flag;
  assign stamp_event = stamp_flag;

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      t1_sync <= 3'h0;
      t2_sync <= 3'h0;
      ts_sync <= 3'h0;
    end
    else
    begin
      t1_sync <= {t1_sync[1:0], tamper_input_one};
      t2_sync <= {t2_sync[1:0], tamper_input_two};
      ts_sync <= {ts_sync[1:0], stamp_input};
    end
  end

  assign t1_edge = t1_sync[1] && !t1_sync[2];
  assign t2_edge = t2_sync[1] && !t2_sync[2];
  assign ts_event = stamp_enable && ts_sync[1] && !ts_sync[2];

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  tick_divider #(.W(ASYNC_W)) u_async_div (
    .clock(clock),
    .nrst(nrst),
    .hold(init_state_flag),
    .tick_in(1'b1),
    .factor(prescaler[ASYNC_LSB +: ASYNC_W]),
    .tick_out(intermediate_clock)
  );

  tick_divider #(.W(SYNC_W)) u_sync_div (
    .clock(clock),
    .nrst(nrst),
    .hold(init_state_flag),
    .tick_in(intermediate_clock),
    .factor(prescaler[SYNC_W-1:0]),
    .tick_out(calendar_step_clock)
  );

  // ----------------------------------------
  // Init mode, system reset sensitive bits
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst or negedge sys_nrst)
  begin
    if (!nrst || !sys_nrst)
    begin
      init_request <= 1'b0;
      init_state_flag <= 1'b0;
      shadow_synced_flag <= 1'b0;
    end
    else
    begin
      if (wr_locked)
        init_request <= reg_wdata[BIT_INIT_REQ];
      init_state_flag <= init_request;
      if (init_state_flag || shift_pending_flag || shadow_bypass)
        shadow_synced_flag <= 1'b0;
      else if (shadow_copy)
        shadow_synced_flag <= 1'b1;
      else if (wr_locked && !reg_wdata[BIT_SYNCED])
        shadow_synced_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Hardware status flags
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      recal_pending_flag <= 1'b0;
      shift_pending_flag <= 1'b0;
      wakeup_write_allowed <= 1'b1;
      alarm_a_write_allowed <= 1'b1;
      alarm_b_write_allowed <= 1'b1;
    end
    else
    begin
      recal_pending_flag <= calib_write || (recal_pending_flag && !calib_applied);
      shift_pending_flag <= shift_write || (shift_pending_flag && !shift_done);
      wakeup_write_allowed <= !wakeup_enable;
      alarm_a_write_allowed <= !alarm_a_enable && !init_state_flag;
      alarm_b_write_allowed <= !alarm_b_enable && !init_state_flag;
    end
  end

  assign calendar_initialized = (year_now != 8'h00);

  // ----------------------------------------
  // Event flags cleared by writing zero
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      clear_late <= 4'h0;
    else if (wr_status)
      clear_late <= ~reg_wdata[BIT_STAMP:BIT_ALARM_A];
    else
      clear_late <= 4'h0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tamper_one_flag <= 1'b0;
      tamper_two_flag <= 1'b0;
      stamp_overflow_flag <= 1'b0;
    end
    else
    begin
      tamper_one_flag <= t1_edge ||
        (tamper_one_flag && !(wr_status && !reg_wdata[BIT_TAMPER_ONE]));
      tamper_two_flag <= t2_edge ||
        (tamper_two_flag && !(wr_locked && !reg_wdata[BIT_TAMPER_TWO]));
      stamp_overflow_flag <= (ts_event && stamp_flag) ||
        (stamp_overflow_flag && !(wr_status && !reg_wdata[BIT_STAMP_OVF]));
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      stamp_flag <= 1'b0;
      wakeup_flag <= 1'b0;
      alarm_b_flag <= 1'b0;
      alarm_a_flag <= 1'b0;
    end
    else
    begin
      stamp_flag <= ts_event || (stamp_flag && !clear_late[3]);
      wakeup_flag <= wake_set || (wakeup_flag && !clear_late[2]);
      alarm_b_flag <= set_b || (alarm_b_flag && !clear_late[1]);
      alarm_a_flag <= set_a || (alarm_a_flag && !clear_late[0]);
    end
  end

  // ----------------------------------------
  // Alarms
  // ----------------------------------------
  alarm_match u_alarm_a (
    .clock(clock),
    .nrst(nrst),
    .alarm(alarm_a),
    .time_now(time_now),
    .date_now(date_now),
    .weekday_now(weekday_now),
    .match(match_a)
  );

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      match_a_prev <= 1'b0;
    else
      match_a_prev <= match_a;
  end

  assign set_a = alarm_a_enable && match_a && !match_a_prev;
  assign set_b = alarm_b_enable && alarm_b_match;

  // ----------------------------------------
  // Wakeup clock and timer
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      kernel_div <= 4'h0;
    else
      kernel_div <= kernel_div + 4'h1;
  end

  always_comb
  begin
    case (wakeup_clock_select)
      3'h0: wakeup_clock = (kernel_div == 4'hF);
      3'h1: wakeup_clock = (kernel_div[2:0] == 3'h7);
      3'h2: wakeup_clock = (kernel_div[1:0] == 2'h3);
      3'h3: wakeup_clock = kernel_div[0];
      default: wakeup_clock = calendar_step_clock;
    endcase
  end

  // Bit 16 only when the step clock with extension is chosen
  assign wake_load = {wakeup_clock_select[2] && wakeup_clock_select[1],
    wakeup_reload[RELOAD_W-1:0]};
  assign wake_set = (wake_state == WK_RUN) && wakeup_enable &&
    wakeup_clock && (wake_count == 17'h00000);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_state <= WK_IDLE;
      wake_count <= 17'h00000;
    end
    else
    begin
      case (wake_state)
        WK_IDLE:
        begin
          if (wakeup_enable)
          begin
            wake_state <= WK_RUN;
            wake_count <= wake_load;
          end
        end
        WK_RUN:
        begin
          if (!wakeup_enable)
            wake_state <= WK_IDLE;
          else if (wakeup_clock)
          begin
            if (wake_count == 17'h00000)
              wake_count <= wake_load;
            else
              wake_count <= wake_count - 17'h00001;
          end
        end
        default: wake_state <= WK_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      prescaler <= RST_PRESCALER;
      wakeup_reload <= RST_WAKEUP;
      alarm_a <= RST_ALARM_A;
    end
    else if (reg_write && write_unlocked)
    begin
      if (reg_addr == OFS_PRESCALER)
        prescaler <= {9'h000, reg_wdata[22:16], 1'b0, reg_wdata[14:0]};
      if (reg_addr == OFS_WAKEUP && wakeup_write_allowed)
        wakeup_reload <= {16'h0000, reg_wdata[15:0]};
      if (reg_addr == OFS_ALARM_A && (alarm_a_write_allowed || init_state_flag))
        alarm_a <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  always_comb
  begin
    status = 32'h00000000;
    status[BIT_RECAL] = recal_pending_flag;
    status[BIT_TAMPER_TWO] = tamper_two_flag;
    status[BIT_TAMPER_ONE] = tamper_one_flag;
    status[BIT_STAMP_OVF] = stamp_overflow_flag;
    status[BIT_STAMP] = stamp_flag;
    status[BIT_WAKEUP] = wakeup_flag;
    status[BIT_ALARM_B] = alarm_b_flag;
    status[BIT_ALARM_A] = alarm_a_flag;
    status[BIT_INIT_REQ] = init_request;
    status[BIT_INIT_STATE] = init_state_flag;
    status[BIT_SYNCED] = shadow_synced_flag;
    status[BIT_CAL_INIT] = calendar_initialized;
    status[BIT_SHIFT] = shift_pending_flag;
    status[BIT_WAKE_WR] = wakeup_write_allowed;
    status[BIT_ALB_WR] = alarm_b_write_allowed;
    status[BIT_ALA_WR] = alarm_a_write_allowed;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h00000000;
    else if (reg_read)
    begin
      case (reg_addr)
        OFS_STATUS: reg_rdata <= status;
        OFS_PRESCALER: reg_rdata <= prescaler;
        OFS_WAKEUP: reg_rdata <= wakeup_reload;
        OFS_ALARM_A: reg_rdata <= alarm_a;
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_recal;
    @(posedge clock) disable iff (!nrst)
      calib_write |=> recal_pending_flag;
  endproperty
  a_recal: assert property (p_recal) else $error("recal pending not set");

  property p_tamper;
    @(posedge clock) disable iff (!nrst)
      t1_edge |=> tamper_one_flag;
  endproperty
  a_tamper: assert property (p_tamper) else $error("tamper flag not set");

  property p_overflow;
    @(posedge clock) disable iff (!nrst)
      (ts_event && stamp_flag) |=> (stamp_overflow_flag && stamp_flag);
  endproperty
  a_overflow: assert property (p_overflow) else $error("stamp overflow missed");

  property p_wake;
    @(posedge clock) disable iff (!nrst)
      (wake_set && !wakeup_flag) |=> (wakeup_flag && (wake_count == $past(wake_load)));
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup flag or reload wrong");

  property p_late_clear;
    @(posedge clock) disable iff (!nrst)
      (wr_status && !reg_wdata[BIT_ALARM_A]) ##1 !set_a |=> !alarm_a_flag;
  endproperty
  a_late_clear: assert property (p_late_clear) else $error("alarm flag not cleared in time");

  property p_init;
    @(posedge clock) disable iff (!nrst || !sys_nrst)
      init_request ##1 init_request |-> init_state_flag && calendar_hold;
  endproperty
  a_init: assert property (p_init) else $error("init state not entered");

  property p_synced;
    @(posedge clock) disable iff (!nrst || !sys_nrst)
      (init_state_flag || shadow_bypass) |=> !shadow_synced_flag;
  endproperty
  a_synced: assert property (p_synced) else $error("synced flag not cleared");

  property p_wake_wr;
    @(posedge clock) disable iff (!nrst)
      !wakeup_enable ##1 !wakeup_enable |-> wakeup_write_allowed;
  endproperty
  a_wake_wr: assert property (p_wake_wr) else $error("wakeup write allowed late");
endmodule : rtc_status_core

// ### rtc_status_core_tb.sv
// Self-checking testbench for the clock status, prescaler, wakeup and alarm slice
`timescale 1ns/1ps
module rtc_status_core_tb;
  import rtc_status_pkg::*;
  // ----------------------------------------
  // Stimulus, observation and design
  // ----------------------------------------
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic sys_nrst = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [31:0] reg_rdata;
  logic write_unlocked = 1'b0;
  logic [8:0] ev = 9'h000;
  logic shadow_bypass = 1'b0;
  logic stamp_enable = 1'b1;
  logic wakeup_enable = 1'b0;
  logic [2:0] wakeup_clock_select = 3'h0;
  logic alarm_a_enable = 1'b0;
  logic alarm_b_enable = 1'b0;
  logic [22:0] time_now = 23'h000000;
  logic [5:0] date_now = 6'h00;
  logic [2:0] weekday_now = 3'h1;
  logic [7:0] year_now = 8'h00;
  logic calendar_hold, intermediate_clock, calendar_step_clock, calib_blocked;
  logic wakeup_event, alarm_a_event, stamp_event;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int div_by[6] = '{16, 8, 4, 2, 20, 20};
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  rtc_status_core DUT (.clock(clock), .nrst(nrst), .sys_nrst(sys_nrst), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .write_unlocked(write_unlocked), .calib_write(ev[0]), .calib_applied(ev[1]), .shift_write(ev[2]),
    .shift_done(ev[3]), .shadow_copy(ev[4]), .shadow_bypass(shadow_bypass), .tamper_input_one(ev[5]),
    .tamper_input_two(ev[6]), .stamp_input(ev[7]), .stamp_enable(stamp_enable),
    .wakeup_enable(wakeup_enable), .wakeup_clock_select(wakeup_clock_select),
    .alarm_a_enable(alarm_a_enable), .alarm_b_enable(alarm_b_enable), .alarm_b_match(ev[8]),
    .time_now(time_now), .date_now(date_now), .weekday_now(weekday_now), .year_now(year_now),
    .calendar_hold(calendar_hold), .intermediate_clock(intermediate_clock),
    .calendar_step_clock(calendar_step_clock), .calib_blocked(calib_blocked),
    .wakeup_event(wakeup_event), .alarm_a_event(alarm_a_event), .stamp_event(stamp_event));

  initial
  begin
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    rd_pend <= reg_read;
  end

  // ----------------------------------------
  // Read data monitor, oldest note first
  // ----------------------------------------
  always @(negedge clock)
  begin
    if (rd_pend)
    begin
      if (exp_q.size() == 0)
        chk(32'h0, 32'h1, "read without note");
      else
        chk(reg_rdata & msk_q.pop_front(), exp_q.pop_front(), "read data");
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clock);
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_write = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(negedge clock);
    reg_read = 1'b1;
    reg_addr = a;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(negedge clock);
    reg_read = 1'b0;
  endtask : rd

  task automatic pulse(input int k);
    @(negedge clock);
    ev[k] = 1'b1;
    @(negedge clock);
    ev[k] = 1'b0;
  endtask : pulse

  function automatic logic sig(input int k);
    case (k)
      0: return wakeup_event;
      1: return intermediate_clock;
      default: return calendar_step_clock;
    endcase
  endfunction : sig

  task automatic wait_lvl(input int k, input logic lvl);
    int i;
    for (i = 0; i < 3000 && sig(k) !== lvl; i++)
      @(negedge clock);
    if (i == 3000)
    begin
      chk(32'h0, 32'h1, "wait ran out");
      results();
    end
  endtask : wait_lvl

  task automatic gap(input int k, input int e);
    int t;
    wait_lvl(k, 1'b1);
    t = cyc;
    tick(1);
    wait_lvl(k, 1'b1);
    chk(32'(cyc - t), 32'(e), "tick spacing");
  endtask : gap

  task automatic alarm_try(input logic [31:0] a, input logic [6:0] sb, input logic [6:0] sg,
                           input logic [2:0] wb, input logic [2:0] wg);
    alarm_a_enable = 1'b0;
    tick(3);
    wr(OFS_STATUS, 32'h00003E00);
    wr(OFS_ALARM_A, a);
    rd(OFS_ALARM_A, a, '1);
    time_now = {16'($urandom), sb};
    weekday_now = wb;
    date_now = 6'($urandom);
    alarm_a_enable = 1'b1;
    tick(5);
    chk(32'(alarm_a_event), 32'h0, "alarm before match");
    wr(OFS_ALARM_A, ~a);
    rd(OFS_ALARM_A, a, '1);
    time_now[6:0] = sg;
    weekday_now = wg;
    tick(5);
    chk(32'(alarm_a_event), 32'h1, "alarm on match");
  endtask : alarm_try

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int n;
    int t0;
    void'($urandom(19010));
    repeat (4) @(posedge clock);
    @(negedge clock);
    nrst = 1'b1;
    rd(OFS_STATUS, 32'h00000007, '1);
    rd(OFS_PRESCALER, 32'h007F00FF, '1);
    rd(OFS_WAKEUP, 32'h0000FFFF, '1);
    rd(OFS_ALARM_A, 32'h00000000, '1);
    rd(8'h08, 32'h00000000, '1);
    year_now = 8'h21;
    rd(OFS_STATUS, 32'h00000017, '1);
    wr(OFS_STATUS, 32'h00003FC0);
    wr(OFS_PRESCALER, 32'h00000000);
    rd(OFS_STATUS, 32'h00000017, '1);
    rd(OFS_PRESCALER, 32'h007F00FF, '1);
    $display("test reset and protection finished");
    write_unlocked = 1'b1;
    alarm_b_enable = 1'b1;
    wr(OFS_STATUS, 32'h00003F80);
    tick(2);
    rd(OFS_STATUS, 32'h000000D4, '1);
    chk(32'(calendar_hold), 32'h1, "hold in init");
    wr(OFS_PRESCALER, 32'h00030000);
    wr(OFS_PRESCALER, 32'h00030004);
    rd(OFS_PRESCALER, 32'h00030004, '1);
    wr(OFS_ALARM_A, 32'h12345678);
    rd(OFS_ALARM_A, 32'h12345678, '1);
    wr(OFS_STATUS, 32'h00003F00);
    tick(2);
    rd(OFS_STATUS, 32'h00000015, '1);
    gap(1, 4);
    gap(2, 20);
    $display("test init and prescaler finished");
    write_unlocked = 1'b0;
    pulse(5);
    pulse(6);
    pulse(7);
    pulse(7);
    pulse(8);
    tick(4);
    chk(32'(stamp_event), 32'h1, "stamp flag");
    rd(OFS_STATUS, 32'h00007A15, '1);
    wr(OFS_STATUS, 32'h00003700);
    chk(32'(stamp_event), 32'h1, "stamp held one cycle");
    tick(2);
    chk(32'(stamp_event), 32'h0, "stamp cleared");
    rd(OFS_STATUS, 32'h00007215, '1);
    wr(OFS_STATUS, 32'h00000000);
    tick(2);
    rd(OFS_STATUS, 32'h00004015, '1);
    stamp_enable = 1'b0;
    pulse(7);
    tick(4);
    chk(32'(stamp_event), 32'h0, "stamp while disabled");
    stamp_enable = 1'b1;
    write_unlocked = 1'b1;
    wr(OFS_STATUS, 32'h00003F00);
    $display("test event flags finished");
    pulse(0);
    chk(32'(calib_blocked), 32'h1, "recal pending");
    pulse(2);
    pulse(4);
    rd(OFS_STATUS, 32'h0001001D, '1);
    pulse(3);
    pulse(1);
    pulse(4);
    rd(OFS_STATUS, 32'h00000035, '1);
    chk(32'(calib_blocked), 32'h0, "recal applied");
    wr(OFS_STATUS, 32'h00003F28);
    rd(OFS_STATUS, 32'h00000035, '1);
    shadow_bypass = 1'b1;
    tick(2);
    rd(OFS_STATUS, 32'h00000015, '1);
    shadow_bypass = 1'b0;
    pulse(0);
    wr(OFS_STATUS, 32'h00003FA0);
    tick(2);
    rd(OFS_STATUS, 32'h000100D4, '1);
    sys_nrst = 1'b0;
    tick(1);
    sys_nrst = 1'b1;
    tick(3);
    rd(OFS_STATUS, 32'h00010015, '1);
    rd(OFS_PRESCALER, 32'h00030004, '1);
    pulse(1);
    $display("test pending flags and system reset finished");
    for (int s = 0; s < 6; s++)
    begin
      wakeup_clock_select = 3'(s);
      tick(3);
      rd(OFS_STATUS, 32'h00000004, 32'h00000004);
      n = 2 + int'($urandom % 3);
      wr(OFS_WAKEUP, 32'(n));
      rd(OFS_WAKEUP, 32'(n), '1);
      wakeup_enable = 1'b1;
      wait_lvl(0, 1'b1);
      t0 = cyc;
      wr(OFS_STATUS, 32'h00003B00);
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
      chk(32'(cyc - t0), 32'((n + 1) * div_by[s]), "wakeup period");
      rd(OFS_STATUS, 32'h00000000, 32'h00000004);
      wr(OFS_WAKEUP, 32'h0000FFFF);
      rd(OFS_WAKEUP, 32'(n), '1);
      wakeup_enable = 1'b0;
      tick(3);
      wr(OFS_STATUS, 32'h00003B00);
    end
    wakeup_clock_select = 3'h6;
    wakeup_enable = 1'b1;
    tick(250);
    chk(32'(wakeup_event), 32'h0, "extended reload");
    wakeup_enable = 1'b0;
    $display("test wakeup timer finished");
    alarm_try(32'h80808045, 7'h44, 7'h45, 3'h2, 3'h3);
    alarm_try(32'h73808080, 7'h11, 7'h12, 3'h2, 3'h3);
    rd(OFS_STATUS, 32'h00000100, 32'h00000100);
    tick(2);
    $display("test alarm compare finished");
    results();
  end
endmodule : rtc_status_core_tb
